// ===== periph_model.sv
// behavioural peripheral side feeding outputs and enables into the mux
module periph_model import pin_mux_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    output periph_drive_t periph
);
    timeunit 1ns;
    timeprecision 1ps;

    // lfsr pattern: neighbouring signals differ often, so a wrong route shows
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph <= 20'h5A3C1;
        end else begin
            periph <= {periph[18:0], periph[19] ^ periph[16]};
        end
    end
endmodule // periph_model

// ===== pin_mux_apb_regs.sv
// apb slave holding the select and mode registers
module pin_mux_apb_regs import pin_mux_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic protected_write_enable,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic [31:0] port_a_low_pin_function_select,
    output logic [31:0] port_a_mux_config
);
    logic [31:0] next_select;
    logic [31:0] next_config;
    logic access;
    logic hit_sel;
    logic hit_cfg;

    assign access = psel && penable;
    assign hit_sel = paddr == SELECT_OFFSET;
    assign hit_cfg = paddr == CONFIG_OFFSET;
    assign pready = 1'b1;
    assign pslverr = access && !hit_sel && !hit_cfg;

    // writes land only while protection is lifted
    always_comb begin
        next_select = port_a_low_pin_function_select;
        next_config = port_a_mux_config;
        if (access && pwrite && protected_write_enable) begin
            if (hit_sel) next_select = pwdata;
            if (hit_cfg) next_config = {31'h0000_0000, pwdata[MODE_BIT]};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_low_pin_function_select <= SELECT_RESET;
            port_a_mux_config <= CONFIG_RESET;
        end else begin
            port_a_low_pin_function_select <= next_select;
            port_a_mux_config <= next_config;
        end
    end

    // read mux is combinational; unmapped reads return zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_sel) prdata = port_a_low_pin_function_select;
        else if (hit_cfg) prdata = port_a_mux_config;
    end

    a_locked_write_ignored: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        access && pwrite && hit_sel && !protected_write_enable |=>
        $stable(port_a_low_pin_function_select))
        else $error("select changed without write enable");
    a_open_write_lands: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        access && pwrite && hit_sel && protected_write_enable |=>
        port_a_low_pin_function_select == $past(pwdata))
        else $error("enabled write not stored");
endmodule // pin_mux_apb_regs

// ===== pin_mux_pin_slice.sv
// one pin of the mux: gpio or one of three alternate functions
module pin_mux_pin_slice import pin_mux_pkg::*; (
    input wire pin_select_t sel,
    input wire logic [3:0] alt_valid,
    input wire pad_drive_t gpio_drive,
    input wire pad_drive_t alt1_drive,
    input wire pad_drive_t alt2_drive,
    input wire pad_drive_t alt3_drive,
    output pad_drive_t pad
);
    // reserved choices leave the pad undriven rather than float a guess
    always_comb begin
        pad = '0;
        case (sel)
            SEL_GPIO: pad = gpio_drive;
            SEL_ALT1: if (alt_valid[1]) pad = alt1_drive;
            SEL_ALT2: if (alt_valid[2]) pad = alt2_drive;
            SEL_ALT3: if (alt_valid[3]) pad = alt3_drive;
            default: pad = '0;
        endcase
    end
endmodule // pin_mux_pin_slice

// ===== pin_mux_pkg.sv
// shared constants and carriers for the port a low pin function mux
package pin_mux_pkg;
    localparam logic [11:0] SELECT_OFFSET = 12'h000;
    localparam logic [11:0] CONFIG_OFFSET = 12'h004;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int FIELD_WIDTH = 2;
    localparam int FIRST_PIN = 3;
    localparam int LAST_PIN = 7;
    localparam int NUM_PINS = 5;
    localparam int MODE_BIT = 0;

    typedef enum logic [1:0] {
        SEL_GPIO = 2'b00,
        SEL_ALT1 = 2'b01,
        SEL_ALT2 = 2'b10,
        SEL_ALT3 = 2'b11
    } pin_select_t;

    // one pin's worth of pad-facing signals
    typedef struct packed {
        logic out;
        logic oe;
    } pad_drive_t;

    // peripheral outputs and enables feeding the mux
    typedef struct packed {
        logic pwm2_output_b;
        logic pwm3_output_a;
        logic pwm3_output_b;
        logic pwm4_output_a;
        logic pwm4_output_b;
        logic pwm5_output_a;
        logic pwm6_output_a;
        logic pwm7_output_a;
        logic pwm8_output_a;
        logic pwm_sync_output;
        logic spi4_clock_out;
        logic spi4_clock_oe;
        logic spi4_transmit_enable_out;
        logic spi4_transmit_enable_oe;
        logic spi4_slave_out_master_in_out;
        logic spi4_slave_out_master_in_oe;
        logic capture_unit_1_out;
        logic capture_unit_1_oe;
        logic capture_unit_2_out;
        logic capture_unit_2_oe;
    } periph_drive_t;

    // pin levels routed back to peripherals
    typedef struct packed {
        logic pwm_sync_input;
        logic spi4_clock_in;
        logic spi4_transmit_enable_in;
        logic spi4_slave_out_master_in_in;
        logic capture_unit_1_in;
        logic capture_unit_2_in;
    } periph_sense_t;

    // extract the select field of pin n
    function automatic pin_select_t field_of(input logic [31:0] r,
                                             input int n);
        field_of = pin_select_t'(r[FIELD_WIDTH*n +: FIELD_WIDTH]);
    endfunction
endpackage

// ===== port_a_low_pin_function_mux.sv
// port a pins 3..7 function mux with apb register access
module port_a_low_pin_function_mux import pin_mux_pkg::*; #(
    parameter bit VARIANT = 1'b1,
    parameter bit HAS_SPI4 = 1'b1,
    parameter bit HAS_CAPTURE = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic protected_write_enable,
    input wire periph_drive_t periph,
    output periph_sense_t sense,
    input wire logic [LAST_PIN:FIRST_PIN] gpio_out,
    input wire logic [LAST_PIN:FIRST_PIN] gpio_oe,
    output logic [LAST_PIN:FIRST_PIN] gpio_in,
    input wire logic [LAST_PIN:FIRST_PIN] pad_in,
    output logic [LAST_PIN:FIRST_PIN] pad_out,
    output logic [LAST_PIN:FIRST_PIN] pad_oe
);
    logic [31:0] select_reg;
    logic [31:0] config_reg;
    logic pwm_mode_field;
    logic [LAST_PIN:FIRST_PIN] pad_meta;
    logic [LAST_PIN:FIRST_PIN] pad_sync;
    logic [LAST_PIN:FIRST_PIN] next_pad_meta;
    logic [LAST_PIN:FIRST_PIN] next_pad_sync;
    pin_select_t pin3_select_field;
    pin_select_t pin4_select_field;
    pin_select_t pin5_select_field;
    pin_select_t pin6_select_field;
    pin_select_t pin7_select_field;
    pin_select_t sel [LAST_PIN:FIRST_PIN];
    pad_drive_t alt1 [LAST_PIN:FIRST_PIN];
    pad_drive_t alt2 [LAST_PIN:FIRST_PIN];
    pad_drive_t alt3 [LAST_PIN:FIRST_PIN];
    logic [3:0] valid [LAST_PIN:FIRST_PIN];
    pad_drive_t pad [LAST_PIN:FIRST_PIN];

    pin_mux_apb_regs u_pin_mux_apb_regs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .protected_write_enable(protected_write_enable),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .port_a_low_pin_function_select(select_reg),
        .port_a_mux_config(config_reg)
    );

    // each field decoded from its own slot, independent of neighbours
    assign pin3_select_field = field_of(select_reg, 3);
    assign pin4_select_field = field_of(select_reg, 4);
    assign pin5_select_field = field_of(select_reg, 5);
    assign pin6_select_field = field_of(select_reg, 6);
    assign pin7_select_field = field_of(select_reg, 7);
    assign sel[3] = pin3_select_field;
    assign sel[4] = pin4_select_field;
    assign sel[5] = pin5_select_field;
    assign sel[6] = pin6_select_field;
    assign sel[7] = pin7_select_field;

    // mode bit only has effect on the variant part
    assign pwm_mode_field = VARIANT && config_reg[MODE_BIT];

    // pwm choices on value 01, remapped by the mode bit
    always_comb begin
        alt1[7] = '{out: pwm_mode_field ? periph.pwm8_output_a
                                        : periph.pwm4_output_b,
                    oe: 1'b1};
        alt1[6] = '{out: pwm_mode_field ? periph.pwm7_output_a
                                        : periph.pwm4_output_a,
                    oe: 1'b1};
        alt1[5] = '{out: pwm_mode_field ? periph.pwm6_output_a
                                        : periph.pwm3_output_b,
                    oe: 1'b1};
        alt1[4] = '{out: pwm_mode_field ? periph.pwm5_output_a
                                        : periph.pwm3_output_a,
                    oe: 1'b1};
        alt1[3] = '{out: pwm_mode_field ? periph.pwm4_output_a
                                        : periph.pwm2_output_b,
                    oe: 1'b1};
    end

    // serial, capture and pwm sync choices on values 10 and 11
    always_comb begin
        alt2[7] = '{out: periph.spi4_transmit_enable_out,
                    oe: periph.spi4_transmit_enable_oe};
        alt3[7] = '{out: periph.capture_unit_2_out,
                    oe: periph.capture_unit_2_oe};
        alt2[6] = '{out: 1'b0, oe: 1'b0}; // sync input only
        alt3[6] = '{out: periph.pwm_sync_output, oe: 1'b1};
        alt2[5] = '{out: periph.spi4_clock_out,
                    oe: periph.spi4_clock_oe};
        alt3[5] = '{out: periph.capture_unit_1_out,
                    oe: periph.capture_unit_1_oe};
        alt2[4] = '0; // reserved
        alt3[4] = '0;
        alt2[3] = '{out: periph.spi4_slave_out_master_in_out,
                    oe: periph.spi4_slave_out_master_in_oe};
        alt3[3] = '0; // reserved
    end

    // which choices exist on this build; absent peripherals are reserved
    always_comb begin
        valid[7] = {HAS_CAPTURE, HAS_SPI4, 1'b1, 1'b1};
        valid[6] = 4'hF;
        valid[5] = {HAS_CAPTURE, HAS_SPI4, 1'b1, 1'b1};
        valid[4] = 4'h3;
        valid[3] = {1'b0, HAS_SPI4, 1'b1, 1'b1};
    end

    for (genvar p = FIRST_PIN; p <= LAST_PIN; p++) begin : g_pin
        pad_drive_t gpio_pick;
        assign gpio_pick = '{out: gpio_out[p], oe: gpio_oe[p]};
        pin_mux_pin_slice u_pin_mux_pin_slice (
            .sel(sel[p]),
            .alt_valid(valid[p]),
            .gpio_drive(gpio_pick),
            .alt1_drive(alt1[p]),
            .alt2_drive(alt2[p]),
            .alt3_drive(alt3[p]),
            .pad(pad[p])
        );
        assign pad_out[p] = pad[p].out;
        assign pad_oe[p] = pad[p].oe;
        // a field at 00 hands the pad straight to gpio
        a_gpio_selected: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            sel[p] == SEL_GPIO |->
            pad_out[p] == gpio_out[p] && pad_oe[p] == gpio_oe[p])
            else $error("gpio path not on pad");
    end

    // pads are asynchronous: two flops before any reader
    always_comb begin
        next_pad_meta = pad_in;
        next_pad_sync = pad_meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_meta <= '0;
            pad_sync <= '0;
        end else begin
            pad_meta <= next_pad_meta;
            pad_sync <= next_pad_sync;
        end
    end

    // gpio always sees the pin; a peripheral input sees it only when chosen
    always_comb begin
        gpio_in = pad_sync;
        sense = '0;
        sense.pwm_sync_input = (sel[6] == SEL_ALT2) && pad_sync[6];
        sense.spi4_transmit_enable_in = HAS_SPI4 && (sel[7] == SEL_ALT2)
                                        && pad_sync[7];
        sense.capture_unit_2_in = HAS_CAPTURE && (sel[7] == SEL_ALT3)
                                  && pad_sync[7];
        sense.spi4_clock_in = HAS_SPI4 && (sel[5] == SEL_ALT2)
                              && pad_sync[5];
        sense.capture_unit_1_in = HAS_CAPTURE && (sel[5] == SEL_ALT3)
                                  && pad_sync[5];
        sense.spi4_slave_out_master_in_in = HAS_SPI4
            && (sel[3] == SEL_ALT2) && pad_sync[3];
    end

    a_reset_gpio: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> pad_oe == gpio_oe)
        else $error("pins not on gpio after reset");
    a_pin7_pwm_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin7_select_field == SEL_ALT1 |-> pad_oe[7] && pad_out[7] ==
        (pwm_mode_field ? periph.pwm8_output_a : periph.pwm4_output_b))
        else $error("pin7 pwm mapping wrong");
    a_pin7_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin7_select_field == SEL_ALT3 && HAS_CAPTURE |->
        pad_out[7] == periph.capture_unit_2_out)
        else $error("pin7 capture not routed");
    a_pin6_pwm_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin6_select_field == SEL_ALT1 |-> pad_out[6] ==
        (pwm_mode_field ? periph.pwm7_output_a : periph.pwm4_output_a))
        else $error("pin6 pwm mapping wrong");
    a_pin6_sync_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin6_select_field == SEL_ALT2 |-> !pad_oe[6] &&
        sense.pwm_sync_input == pad_sync[6])
        else $error("pin6 sync input wrong");
    a_pin5_pwm_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin5_select_field == SEL_ALT1 |-> pad_out[5] ==
        (pwm_mode_field ? periph.pwm6_output_a : periph.pwm3_output_b))
        else $error("pin5 pwm mapping wrong");
    a_pin5_spi_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin5_select_field == SEL_ALT2 && HAS_SPI4 |->
        pad_oe[5] == periph.spi4_clock_oe)
        else $error("pin5 spi clock not routed");
    a_pin4_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin4_select_field[1] |-> !pad_oe[4])
        else $error("pin4 reserved drives");
    a_pin3_pwm_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin3_select_field == SEL_ALT1 |-> pad_out[3] ==
        (pwm_mode_field ? periph.pwm4_output_a : periph.pwm2_output_b))
        else $error("pin3 pwm mapping wrong");
    a_pin3_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin3_select_field == SEL_ALT3 |-> !pad_oe[3])
        else $error("pin3 reserved drives");
    a_field_follows_write: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == SELECT_OFFSET &&
        protected_write_enable |=> pin4_select_field == $past(pwdata[9:8]))
        else $error("pin4 field not at bits 9:8");

    // pin input passes exactly two flops; skip edges still fed by reset
    a_gpio_in_sync: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $past(rst_n, 2) |-> gpio_in == $past(pad_in, 2))
        else $error("gpio input not two flops late");
    a_pin7_spi_enable: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin7_select_field == SEL_ALT2 && HAS_SPI4 |->
        pad_out[7] == periph.spi4_transmit_enable_out
        && pad_oe[7] == periph.spi4_transmit_enable_oe)
        else $error("pin7 spi enable not routed");
    a_capture_in_map: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin7_select_field == SEL_ALT3 && HAS_CAPTURE |->
        sense.capture_unit_2_in == pad_sync[7]
        && !sense.spi4_transmit_enable_in)
        else $error("pin7 capture input wrong");
    a_te_in_gated: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin7_select_field != SEL_ALT2 |-> !sense.spi4_transmit_enable_in)
        else $error("spi enable input leaks");
    a_pin6_sync_out: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin6_select_field == SEL_ALT3 |->
        pad_oe[6] && pad_out[6] == periph.pwm_sync_output)
        else $error("pin6 sync output wrong");
    a_sync_in_gated: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin6_select_field != SEL_ALT2 |-> !sense.pwm_sync_input)
        else $error("sync input leaks");
    a_pin5_capture: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin5_select_field == SEL_ALT3 && HAS_CAPTURE |->
        pad_out[5] == periph.capture_unit_1_out
        && pad_oe[5] == periph.capture_unit_1_oe)
        else $error("pin5 capture not routed");
    a_spi_in_gated: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin5_select_field != SEL_ALT2 |-> !sense.spi4_clock_in)
        else $error("spi clock input leaks");
    a_pin4_pwm_map: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin4_select_field == SEL_ALT1 |-> pad_oe[4] && pad_out[4] ==
        (pwm_mode_field ? periph.pwm5_output_a : periph.pwm3_output_a))
        else $error("pin4 pwm mapping wrong");
    a_pin3_spi_somi: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        pin3_select_field == SEL_ALT2 && HAS_SPI4 |->
        pad_out[3] == periph.spi4_slave_out_master_in_out
        && pad_oe[3] == periph.spi4_slave_out_master_in_oe)
        else $error("pin3 spi line not routed");
    a_pin7_field_slot: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == SELECT_OFFSET &&
        protected_write_enable |=> pin7_select_field == $past(pwdata[15:14]))
        else $error("pin7 field not at bits 15:14");
    a_pin3_field_slot: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == SELECT_OFFSET &&
        protected_write_enable |=> pin3_select_field == $past(pwdata[7:6]))
        else $error("pin3 field not at bits 7:6");
    a_mode_write_lands: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == CONFIG_OFFSET &&
        protected_write_enable |=>
        pwm_mode_field == (VARIANT && $past(pwdata[MODE_BIT])))
        else $error("pwm mode bit not stored");
    a_locked_mode_held: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == CONFIG_OFFSET &&
        !protected_write_enable |=> $stable(pwm_mode_field))
        else $error("mode changed without write enable");
    a_select_reset: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $rose(rst_n) |-> select_reg == SELECT_RESET && !pwm_mode_field)
        else $error("fields not cleared by reset");
endmodule // port_a_low_pin_function_mux

// ===== tb_port_a_low_pin_function_mux.sv
// self-checking bench for the port a pins 3..7 function mux
module tb_port_a_low_pin_function_mux import pin_mux_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic protected_write_enable = 1'b1;
    periph_drive_t periph;
    periph_sense_t sense;
    logic [7:3] gpio_out = 5'h05;
    logic [7:3] gpio_oe = 5'h0C;
    logic [7:3] gpio_in;
    logic [7:3] pad_in = 5'h00;
    logic [7:3] pad_out;
    logic [7:3] pad_oe;
    int failures = 0;
    int n_tests = 0;
    logic [31:0] sel;
    logic [5:0] exp_sense;

    port_a_low_pin_function_mux u_port_a_low_pin_function_mux (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata),
        .protected_write_enable(protected_write_enable),
        .periph(periph), .sense(sense), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_in(gpio_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe)
    );

    periph_model u_periph_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .periph(periph)
    );

    // clock at 40 mhz
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // gpio drive keeps moving so the 00 path is exercised every cycle
    always @(posedge sys_clk) begin
        gpio_out <= gpio_out + 5'h03;
        gpio_oe <= gpio_oe ^ gpio_out;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; holds the request until pready is seen high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic apb_write(logic [11:0] a, logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic apb_read(logic [11:0] a, logic [31:0] exp, logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check("prdata", rd, exp);
        check("pslverr", 32'(err), 32'(exp_err));
        check("pready", 32'(pready), 32'h0000_0001);
    endtask

    // expected {out, oe} of pin p for select value v and pwm mode m
    function automatic logic [1:0] exp_pad(int p, logic [1:0] v, logic m);
        periph_drive_t d;
        logic [4:0] k;
        d = periph;
        k = {p[2:0], v};
        if (v == 2'b00) begin
            return {gpio_out[p], gpio_oe[p]};
        end
        case (k)
            5'h1D: return {m ? d.pwm8_output_a : d.pwm4_output_b, 1'b1};
            5'h1E: return {d.spi4_transmit_enable_out,
                           d.spi4_transmit_enable_oe};
            5'h1F: return {d.capture_unit_2_out, d.capture_unit_2_oe};
            5'h19: return {m ? d.pwm7_output_a : d.pwm4_output_a, 1'b1};
            5'h1B: return {d.pwm_sync_output, 1'b1};
            5'h15: return {m ? d.pwm6_output_a : d.pwm3_output_b, 1'b1};
            5'h16: return {d.spi4_clock_out, d.spi4_clock_oe};
            5'h17: return {d.capture_unit_1_out, d.capture_unit_1_oe};
            5'h11: return {m ? d.pwm5_output_a : d.pwm3_output_a, 1'b1};
            5'h0D: return {m ? d.pwm4_output_a : d.pwm2_output_b, 1'b1};
            5'h0E: return {d.spi4_slave_out_master_in_out,
                           d.spi4_slave_out_master_in_oe};
            default: return 2'b00; // reserved and input-only choices
        endcase
    endfunction

    // compare every pin against its expected drive for a few cycles
    task automatic check_pads(logic [31:0] s, logic m);
        repeat (6) begin
            @(negedge sys_clk);
            for (int p = FIRST_PIN; p <= LAST_PIN; p++) begin
                check("pad", 32'({pad_out[p], pad_oe[p]}),
                      32'(exp_pad(p, s[2*p +: 2], m)));
            end
        end
        @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        apb_read(SELECT_OFFSET, SELECT_RESET, 1'b0);
        apb_read(CONFIG_OFFSET, CONFIG_RESET, 1'b0);
        check_pads(32'h0000_0000, 1'b0);
        $display("test reset done");
        // protection low: write must vanish without an error
        protected_write_enable <= 1'b0;
        apb_write(SELECT_OFFSET, 32'h0000_5540);
        apb_read(SELECT_OFFSET, 32'h0000_0000, 1'b0);
        apb_write(CONFIG_OFFSET, 32'h0000_0001);
        apb_read(CONFIG_OFFSET, 32'h0000_0000, 1'b0);
        protected_write_enable <= 1'b1;
        apb_read(12'h008, 32'h0000_0000, 1'b1);
        apb_write(SELECT_OFFSET, 32'hFFFF_FFFF);
        apb_read(SELECT_OFFSET, 32'hFFFF_FFFF, 1'b0);
        apb_write(CONFIG_OFFSET, 32'hFFFF_FFFF);
        apb_read(CONFIG_OFFSET, 32'h0000_0001, 1'b0);
        $display("test access done");
        // every non-reserved code on every pin, pins offset so fields differ
        for (int m = 0; m < 2; m++) begin
            apb_write(CONFIG_OFFSET, 32'(m));
            for (int v = 0; v < 4; v++) begin
                sel = 32'h0000_0000;
                for (int p = FIRST_PIN; p <= LAST_PIN; p++) begin
                    sel[2*p +: 2] = 2'(v + p);
                    // software keeps off the reserved codes
                    if (p == 4 && sel[9]) begin
                        sel[9:8] = 2'b00;
                    end
                    if (p == 3 && sel[7:6] == 2'b11) begin
                        sel[7:6] = 2'b00;
                    end
                end
                apb_write(SELECT_OFFSET, sel);
                apb_read(SELECT_OFFSET, sel, 1'b0);
                check_pads(sel, m[0]);
            end
        end
        $display("test routing done");
        // inputs: pad level reaches the selected peripheral two edges on
        for (int c = 0; c < 4; c++) begin
            sel = c[0] ? 32'h0000_CC00 : 32'h0000_A880;
            apb_write(SELECT_OFFSET, sel);
            pad_in <= c[1] ? 5'h0A : 5'h15;
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            exp_sense = c[0] ? {4'h0, pad_in[5], pad_in[7]} :
                {pad_in[6], pad_in[5], pad_in[7], pad_in[3], 2'b00};
            check("sense", 32'(sense), 32'(exp_sense));
            check("gpio_in", 32'(gpio_in), 32'(pad_in));
            @(posedge sys_clk);
        end
        $display("test inputs done");
        // second reset in mid-run returns every field to gpio
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        apb_read(SELECT_OFFSET, SELECT_RESET, 1'b0);
        check_pads(32'h0000_0000, 1'b0);
        $display("test second reset done");
        summarize();
    end
endmodule // tb_port_a_low_pin_function_mux
